/* File: hdl/chgctl_pkg.sv */
// constants, types and register map of the charger control logic
package chgctl_pkg;

    localparam int          CLK_NS        = 5;
    localparam longint      T15_MIN       = 15;
    localparam longint      T32_S         = 32;
    localparam longint      FAULT_PULSE_NS = 128000;
    localparam longint      T15_CYC  = T15_MIN * 60 * 1000000000 / CLK_NS;
    localparam longint      T32_CYC  = T32_S * 1000000000 / CLK_NS;
    localparam longint      FAULT_CYC = FAULT_PULSE_NS / CLK_NS;
    localparam int          TMR_W         = 40;
    localparam int          PULSE_W       = 16;

    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_SAFETY   = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h10;

    localparam int          CTRL_STAT_EN  = 0;
    localparam int          CTRL_BOOST_EN = 1;
    localparam int          CTRL_MODE32   = 2;
    localparam int          CTRL_TERM_EN  = 3;
    localparam int          CTRL_TMR_RST  = 4;
    localparam logic [3:0]  CTRL_RST      = 4'h9;
    localparam logic [7:0]  SAFETY_RST    = 8'h00;

    localparam int          IRQ_W         = 4;
    localparam int          IRQ_FAULT     = 0;
    localparam int          IRQ_DONE      = 1;
    localparam int          IRQ_RECHG     = 2;
    localparam int          IRQ_TMR       = 3;

    typedef enum logic [7:0] {
        ST_SLEEP = 8'h01,
        ST_IDLE  = 8'h02,
        ST_COND  = 8'h04,
        ST_CC    = 8'h08,
        ST_CV    = 8'h10,
        ST_DONE  = 8'h20,
        ST_FAULT = 8'h40,
        ST_BOOST = 8'h80
    } chgctl_state_e;

    typedef struct packed {
        logic supply_ok;
        logic batt_above_cond;
        logic batt_at_reg;
        logic batt_below_rechg;
        logic current_below_term;
        logic junction_hot;
        logic analog_fault;
        logic charge_disable;
        logic boost_or_limit_select;
        logic limit_lock_reset_n;
    } chgctl_pins_s;

    localparam int PINS_W = $bits(chgctl_pins_s);

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } chgctl_apb_req_s;

    typedef struct packed {
        chgctl_state_e          st;
        logic [3:0]             ctrl;
        logic [7:0]             safety;
        logic                   locked;
        logic [IRQ_W-1:0]       irq_st;
        logic [IRQ_W-1:0]       irq_mask;
        logic [TMR_W-1:0]       tmr;
        logic [PULSE_W-1:0]     pulse;
        logic                   cd_q;
        logic [31:0]            rdata;
        logic                   slverr;
    } chgctl_regs_s;

endpackage : chgctl_pkg

/* File: hdl/chgctl_sync.sv */
// two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module chgctl_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_in,
    input  wire logic         rst_b_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } chgctl_sync_s;

    chgctl_sync_s q;
    chgctl_sync_s next_q;

    // first stage feeds only the second stage; one process owns next_q
    always_comb begin
        next_q.meta   = async_in;
        next_q.stable = q.meta;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign sync_out = q.stable;
endmodule : chgctl_sync

/* File: hdl/chgctl_top.sv */
// charger supervisory logic: phase sequencer, timers, status pin, apb regs
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// - the status pin is pulled low while a charge is in progress, else open.
// - a fault gives one low pulse of 128 us on the status pin.
// - the status pin stays released while its enable bit is clear.
// - charge-disable low enables charging, high stops it and floats supply.
// - charge-disable rising restarts the 15 min timer but not the 32 s one.
// - an active boost pin with its boost function enabled forces boost mode.
// - after reset the boost pin selects 500 mA when high and 100 mA when low.
// - while lock reset is low the safety limits sit at default, writes lost.
// - with lock reset high the limits take writes until another reg is hit.
// - charging runs conditioning, then constant current, then voltage.
// - a charge ends at regulation voltage with current below termination.
// - a safety timer backs up the host, who must keep resetting it.
// - a finished battery that sags below recharge level restarts charging.
// - losing the input supply drops the logic into sleep automatically, except in boost mode.
// - charge current is reduced once the junction reaches about 125 C.
// - the charge status can be read by the host.
module chgctl_top
    import chgctl_pkg::*;
#(
    parameter longint T15_CYCLES   = chgctl_pkg::T15_CYC,
    parameter longint T32_CYCLES   = chgctl_pkg::T32_CYC,
    parameter longint PULSE_CYCLES = chgctl_pkg::FAULT_CYC
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [7:0]            paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    input  wire chgctl_pkg::chgctl_pins_s pins_in,
    output logic                       stat_out,
    output logic                       stat_oe_out,
    output logic                       charge_enable_out,
    output logic                       supply_hiz_out,
    output logic                       sleep_out,
    output logic                       boost_mode_out,
    output logic                       input_limit_500_out,
    output logic                       current_reduce_out,
    output logic                       irq_out
);
    import chgctl_pkg::*;

    chgctl_regs_s     q;
    chgctl_regs_s     next_q;
    chgctl_pins_s     pin;
    chgctl_apb_req_s  req;
    logic [PINS_W-1:0] pin_vec;

    chgctl_sync #(
        .W (PINS_W)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .async_in   (pins_in),
        .sync_out   (pin_vec)
    );

    assign pin = chgctl_pins_s'(pin_vec);
    assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                   paddr: paddr_in, pwdata: pwdata_in};

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
                   (a == ADDR_SAFETY) || (a == ADDR_IRQ_STAT) ||
                   (a == ADDR_IRQ_MASK);
    endfunction : addr_hit

    function automatic logic is_charging(input chgctl_state_e s);
        is_charging = (s == ST_COND) || (s == ST_CC) || (s == ST_CV);
    endfunction : is_charging

    logic                  wr_en;
    logic                  rd_setup;
    logic                  boost_req;
    logic                  cd_rise;
    logic                  tmr_kick;
    logic                  tmr_expire;
    logic                  fault_evt;
    logic                  done_evt;
    logic                  rechg_evt;
    logic [TMR_W-1:0]      tmr_limit;
    logic [IRQ_W-1:0]      irq_set;
    logic [IRQ_W-1:0]      irq_clr;

    always_comb begin
        next_q     = q;
        // zero-wait slave: write lands at the access edge
        wr_en      = req.psel && req.penable && req.pwrite;
        rd_setup   = req.psel && !req.penable;
        boost_req  = q.ctrl[CTRL_BOOST_EN] && pin.boost_or_limit_select;
        cd_rise    = pin.charge_disable && !q.cd_q;
        tmr_limit  = q.ctrl[CTRL_MODE32] ? TMR_W'(T32_CYCLES)
                                         : TMR_W'(T15_CYCLES);
        tmr_kick   = wr_en && (req.paddr == ADDR_CTRL) &&
                     req.pwdata[CTRL_TMR_RST];
        tmr_expire = is_charging(q.st) && (q.tmr >= tmr_limit - 1'b1);
        fault_evt  = 1'b0;
        done_evt   = 1'b0;
        rechg_evt  = 1'b0;
        irq_set    = '0;
        irq_clr    = '0;
        next_q.cd_q = pin.charge_disable;

        // safety timer counts cycles during charge phases
        if (tmr_kick || (cd_rise && !q.ctrl[CTRL_MODE32])) begin
            next_q.tmr = '0;
        end else if (is_charging(q.st) && !tmr_expire) begin
            next_q.tmr = q.tmr + 1'b1;
        end

        // phase sequencer
        case (q.st)
            ST_SLEEP: begin
                next_q.tmr = '0;
                if (pin.supply_ok) begin
                    next_q.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!pin.charge_disable) begin
                    // no clear here: a 32 s run survives a disable pause
                    next_q.st  = ST_COND;
                end
            end
            ST_COND: begin
                if (pin.batt_above_cond) begin
                    next_q.st = ST_CC;
                end
            end
            ST_CC: begin
                if (pin.batt_at_reg) begin
                    next_q.st = ST_CV;
                end
            end
            ST_CV: begin
                if (pin.batt_at_reg && pin.current_below_term &&
                    q.ctrl[CTRL_TERM_EN]) begin
                    next_q.st = ST_DONE;
                    done_evt  = 1'b1;
                end
            end
            ST_DONE: begin
                if (pin.batt_below_rechg) begin
                    next_q.st  = ST_COND;
                    next_q.tmr = '0;
                    rechg_evt  = 1'b1;
                end
            end
            ST_FAULT: begin
                // leaves when the host kicks the timer, or via the supply and boost overrides
                if (tmr_kick) begin
                    next_q.st = ST_IDLE;
                end
            end
            ST_BOOST: begin
                next_q.tmr = '0;
                if (!boost_req) begin
                    next_q.st = ST_IDLE;
                end
            end
            default: begin
                next_q.st = ST_SLEEP;
            end
        endcase

        // overrides, lowest priority first
        if (is_charging(q.st) && pin.charge_disable) begin
            next_q.st = ST_IDLE;
        end
        if (is_charging(q.st) && (tmr_expire || pin.analog_fault)) begin
            next_q.st = ST_FAULT;
            fault_evt = 1'b1;
        end
        if (!pin.supply_ok && (q.st != ST_BOOST) && !boost_req) begin
            next_q.st = ST_SLEEP;
        end
        if (boost_req) begin
            next_q.st = ST_BOOST;
        end

        // fault pulse: new faults during a pulse are dropped
        if (q.pulse != '0) begin
            next_q.pulse = q.pulse - 1'b1;
        end else if (fault_evt) begin
            next_q.pulse = PULSE_W'(PULSE_CYCLES);
        end

        // safety limit lock
        if (!pin.limit_lock_reset_n) begin
            next_q.safety = SAFETY_RST;
            next_q.locked = 1'b0;
        end else if (wr_en && addr_hit(req.paddr)) begin
            if (req.paddr == ADDR_SAFETY) begin
                if (!q.locked) begin
                    next_q.safety = req.pwdata[7:0];
                end
            end else begin
                next_q.locked = 1'b1;
            end
        end

        // other register writes
        if (wr_en && (req.paddr == ADDR_CTRL)) begin
            next_q.ctrl = req.pwdata[3:0];
        end
        if (wr_en && (req.paddr == ADDR_IRQ_MASK)) begin
            next_q.irq_mask = req.pwdata[IRQ_W-1:0];
        end
        if (wr_en && (req.paddr == ADDR_IRQ_STAT)) begin
            irq_clr = req.pwdata[IRQ_W-1:0];
        end

        // sticky events; a set in the clearing cycle survives
        irq_set[IRQ_FAULT] = fault_evt;
        irq_set[IRQ_DONE]  = done_evt;
        irq_set[IRQ_RECHG] = rechg_evt;
        irq_set[IRQ_TMR]   = is_charging(q.st) && tmr_expire;
        next_q.irq_st      = (q.irq_st & ~irq_clr) | irq_set;

        // read data is fetched in the setup cycle
        if (rd_setup) begin
            next_q.slverr = !addr_hit(req.paddr);
            case (req.paddr)
                ADDR_CTRL:     next_q.rdata = {28'h0, q.ctrl};
                ADDR_STATUS:   next_q.rdata = {21'h0, q.locked,
                                               pin.boost_or_limit_select,
                                               q.pulse != '0,
                                               q.st};
                ADDR_SAFETY:   next_q.rdata = {24'h0, q.safety};
                ADDR_IRQ_STAT: next_q.rdata = {28'h0, q.irq_st};
                ADDR_IRQ_MASK: next_q.rdata = {28'h0, q.irq_mask};
                default:       next_q.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q          <= '0;
            q.st       <= ST_SLEEP;
            q.ctrl     <= CTRL_RST;
            q.safety   <= SAFETY_RST;
        end else begin
            q <= next_q;
        end
    end

    assign pready_out  = 1'b1;
    assign prdata_out  = q.rdata;
    assign pslverr_out = q.slverr && psel_in && penable_in;

    // open drain: only ever pulls low
    assign stat_out    = 1'b0;
    assign stat_oe_out = q.ctrl[CTRL_STAT_EN] &&
                         (is_charging(q.st) || (q.pulse != '0));

    assign charge_enable_out  = is_charging(q.st);
    assign supply_hiz_out     = pin.charge_disable ||
                                (q.st == ST_SLEEP);
    assign sleep_out          = (q.st == ST_SLEEP);
    assign boost_mode_out     = (q.st == ST_BOOST);
    // limit select follows the pin, even while it is claimed for boost
    assign input_limit_500_out = pin.boost_or_limit_select;
    assign current_reduce_out = is_charging(q.st) &&
                                pin.junction_hot;
    assign irq_out            = |(q.irq_st & q.irq_mask);
endmodule : chgctl_top

/* File: dv/chgctl_top_monitor.sv */
// port-level assertion checker for the charger supervisory logic
`timescale 1ns/1ps
module chgctl_top_monitor
    import chgctl_pkg::*;
#(
    parameter longint T15_CYCLES   = 200,
    parameter longint T32_CYCLES   = 100,
    parameter longint PULSE_CYCLES = 20
) (
    input wire logic                     ref_clk_in,
    input wire logic                     rst_b_in,
    input wire logic                     psel_in,
    input wire logic                     penable_in,
    input wire logic                     pwrite_in,
    input wire logic [7:0]               paddr_in,
    input wire logic [31:0]              pwdata_in,
    input wire logic [31:0]              prdata_out,
    input wire logic                     pready_out,
    input wire logic                     pslverr_out,
    input wire chgctl_pkg::chgctl_pins_s pins_in,
    input wire logic                     stat_out,
    input wire logic                     stat_oe_out,
    input wire logic                     charge_enable_out,
    input wire logic                     supply_hiz_out,
    input wire logic                     sleep_out,
    input wire logic                     boost_mode_out,
    input wire logic                     input_limit_500_out,
    input wire logic                     current_reduce_out,
    input wire logic                     irq_out
);
    logic        stat_en;
    logic        boost_en;
    logic [2:0]  up;
    logic [31:0] run;
    wire ctrl_wr = psel_in && penable_in && pwrite_in && pready_out
                   && paddr_in == ADDR_CTRL;
    // shadow of the control bits, seen only through bus writes
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stat_en  <= CTRL_RST[CTRL_STAT_EN];
            boost_en <= CTRL_RST[CTRL_BOOST_EN];
            up       <= 3'h0;
            run      <= 32'h0;
        end else begin
            if (ctrl_wr) begin
                stat_en  <= pwdata_in[CTRL_STAT_EN];
                boost_en <= pwdata_in[CTRL_BOOST_EN];
            end
            // pin checks wait out the synchroniser after reset
            if (up != 3'h7) up <= up + 3'h1;
            run <= (stat_oe_out && !charge_enable_out) ? run + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    chk_stat_low: assert property (stat_out == 1'b0)
        else $error("status pin driven high");
    chk_charge_pulls: assert property (
        (stat_en && charge_enable_out) [*2] |-> stat_oe_out)
        else $error("status pin released while charging");
    chk_stat_masked: assert property (
        !stat_en [*2] |-> !stat_oe_out)
        else $error("status pin active while disabled");
    chk_pulse_bound: assert property (
        run <= PULSE_CYCLES)
        else $error("fault pulse too long");
    chk_disable_hiz: assert property (
        (up == 3'h7 && pins_in.charge_disable) [*4] |-> supply_hiz_out)
        else $error("supply not floated on disable");
    chk_disable_stop: assert property (
        (up == 3'h7 && pins_in.charge_disable) [*5] |-> !charge_enable_out)
        else $error("charging while disabled");
    chk_supply_sleep: assert property (
        (up == 3'h7 && !pins_in.supply_ok) [*5]
        |-> !charge_enable_out && (sleep_out || boost_mode_out))
        else $error("no sleep without supply");
    chk_limit_follow: assert property (
        (up == 3'h7 && $stable(pins_in.boost_or_limit_select)) [*4]
        |-> input_limit_500_out == pins_in.boost_or_limit_select)
        else $error("limit select not following pin");
    chk_boost_force: assert property (
        (up == 3'h7 && boost_en && pins_in.boost_or_limit_select) [*5]
        |-> boost_mode_out)
        else $error("boost not forced by pin");
    chk_hot_reduce: assert property (
        (up == 3'h7 && charge_enable_out && pins_in.junction_hot) [*4]
        |-> current_reduce_out)
        else $error("current not reduced when hot");
endmodule : chgctl_top_monitor

bind chgctl_top chgctl_top_monitor #(
    .T15_CYCLES(T15_CYCLES), .T32_CYCLES(T32_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)
) u_mon (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .pins_in(pins_in),
    .stat_out(stat_out), .stat_oe_out(stat_oe_out),
    .charge_enable_out(charge_enable_out), .supply_hiz_out(supply_hiz_out),
    .sleep_out(sleep_out), .boost_mode_out(boost_mode_out),
    .input_limit_500_out(input_limit_500_out),
    .current_reduce_out(current_reduce_out), .irq_out(irq_out)
);

/* File: dv/chgctl_batt_model.sv */
// cell and supply model driving the charger sense pins
`timescale 1ns/1ps
module chgctl_batt_model
    import chgctl_pkg::*;
(
    input  wire logic                     clk_in,
    input  wire logic                     rst_b_in,
    input  wire logic                     charge_en_in,
    input  wire logic                     drain_in,
    input  wire logic [7:0]               step_in,
    input  wire chgctl_pkg::chgctl_pins_s env_in,
    output chgctl_pkg::chgctl_pins_s      pins_out
);
    logic [7:0] level;
    logic [7:0] tick;
    // a step of zero freezes the cell so the timers can run out
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            level <= 8'h00;
            tick  <= 8'h00;
        end else if (drain_in) begin
            level <= 8'h02;
        end else if (charge_en_in && step_in != 8'h00) begin
            tick <= (tick >= step_in) ? 8'h00 : tick + 8'h01;
            if (tick >= step_in && level < 8'h06) level <= level + 8'h01;
        end
    end
    always_comb begin
        pins_out = env_in;
        pins_out.batt_above_cond    = level >= 8'h02;
        pins_out.batt_at_reg        = level >= 8'h04;
        pins_out.batt_below_rechg   = level < 8'h04;
        pins_out.current_below_term = level >= 8'h06;
    end
endmodule : chgctl_batt_model

/* File: dv/test_charger_control_logic.sv */
// self-checking bench for the charger supervisory logic
`timescale 1ns/1ps
module test_charger_control_logic;
    import chgctl_pkg::*;
    localparam int PP = 20;
    logic clk, rst_b, psel, pen, pwr, drain, pready, perr, stat, oe, chg;
    logic hiz, slp, bst, l500, red, irq, i0;
    logic [7:0] paddr, step, last;
    logic [31:0] pwdata, prdata, rd, d;
    logic [33:0] note;
    logic [7:0] ph [4] = '{8'h04, 8'h08, 8'h10, 8'h20};
    chgctl_pins_s env, pins;
    int miscompares = 0, total_checks = 0, seed = 84, p, k, n_oe = 0;
    logic [33:0] exp_q [$];
    int pq [$];
    chgctl_top #(.T15_CYCLES(200), .T32_CYCLES(100), .PULSE_CYCLES(PP)) u_dut (
        .ref_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
        .pins_in(pins), .stat_out(stat), .stat_oe_out(oe),
        .charge_enable_out(chg), .supply_hiz_out(hiz), .sleep_out(slp),
        .boost_mode_out(bst), .input_limit_500_out(l500),
        .current_reduce_out(red), .irq_out(irq));
    chgctl_batt_model u_batt (.clk_in(clk), .rst_b_in(rst_b),
        .charge_en_in(chg), .drain_in(drain), .step_in(step),
        .env_in(env), .pins_out(pins));
    task automatic stop_test;
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic chk_val(input logic [31:0] g, e, input string s);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %0t %s %0h not %0h", $time, s, g, e);
        end
    endtask : chk_val
    task automatic chk_pin(input logic g, e, input string s);
        chk_val({31'h0, g}, {31'h0, e}, s);
    endtask : chk_pin
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, input logic [33:0] e);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        if (!w) exp_q.push_back(e);
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (t >= 20) miscompares++;
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, 34'h0);
    endtask : wr
    task automatic rx(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, {1'b1, e});
    endtask : rx
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic wait_chg(input logic v, input int lim);
        int t;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (chg !== v && t < lim);
        chk_pin(chg, v, "charge enable");
    endtask : wait_chg
    // read results are judged against the oldest note, fault pulse lengths against the oldest pq entry
    always @(posedge clk) begin
        if (psel && pen && pready && !pwr) begin
            note = exp_q.pop_front();
            if (note[33]) chk_val(prdata, note[31:0], "read data");
            if (note[33]) chk_pin(perr, note[32], "slave error");
        end
        if (oe && !chg) n_oe++;
        else if (n_oe != 0) begin
            chk_val(n_oe, pq.pop_front(), "fault pulse");
            n_oe = 0;
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #400000;
        miscompares++;
        stop_test();
    end
    initial begin
        {rst_b, psel, pen, pwr, paddr, pwdata, drain, step} = '0;
        env = '0;
        env.boost_or_limit_select = 1'b1;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        settle(4);
        chk_pin(l500, 1'b1, "limit select");
        rx(ADDR_CTRL, {28'h0, CTRL_RST});
        rx(ADDR_STATUS, 33'h201);
        rx(8'h14, 33'h1_0000_0000);
        d = ($random(seed) & 32'h7F) | 32'h01;
        wr(ADDR_SAFETY, d);
        rx(ADDR_SAFETY, 33'h0);
        env.limit_lock_reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        wr(ADDR_SAFETY, d);
        rx(ADDR_SAFETY, {1'b0, d});
        wr(ADDR_IRQ_MASK, 32'hF);
        wr(ADDR_SAFETY, ~d & 32'hFF);
        rx(ADDR_SAFETY, {1'b0, d});
        env.limit_lock_reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        rx(ADDR_SAFETY, 33'h0);
        step <= 8'h08 + 8'($random(seed) & 32'h7);
        env.supply_ok <= 1'b1;
        env.boost_or_limit_select <= 1'b0;
        wait_chg(1'b1, 40);
        chk_pin(oe, 1'b1, "status pin");
        p = 0;
        k = 0;
        last = 8'h00;
        // host keeps kicking the timer while the phases advance
        while (last != 8'h20 && k < 60) begin
            wr(ADDR_CTRL, 32'h19);
            apb(1'b0, ADDR_STATUS, 32'h0, 34'h0);
            if (rd[7:0] != last) begin
                chk_val(rd[7:0], ph[p], "phase");
                p++;
                last = rd[7:0];
            end
            k++;
        end
        settle(2);
        chk_pin(oe, 1'b0, "status pin");
        rx(ADDR_IRQ_STAT, 33'h2);
        wr(ADDR_IRQ_MASK, 32'h0);
        settle(1);
        i0 = irq;
        wr(ADDR_IRQ_MASK, 32'hF);
        settle(1);
        chk_pin(irq ^ i0, 1'b1, "irq mask");
        wr(ADDR_IRQ_STAT, 32'h2);
        settle(1);
        chk_pin(irq, 1'b0, "irq clear");
        @(posedge clk);
        drain <= 1'b1;
        step <= 8'h00;
        @(posedge clk);
        drain <= 1'b0;
        wait_chg(1'b1, 20);
        rx(ADDR_IRQ_STAT, 33'h4);
        env.charge_disable <= 1'b1;
        wait_chg(1'b0, 20);
        chk_pin(hiz, 1'b1, "supply float");
        @(posedge clk);
        env.charge_disable <= 1'b0;
        wait_chg(1'b1, 20);
        wr(ADDR_CTRL, 32'h1D);
        pq.push_back(PP);
        repeat (60) @(posedge clk);
        env.charge_disable <= 1'b1;
        repeat (6) @(posedge clk);
        env.charge_disable <= 1'b0;
        wait_chg(1'b1, 20);
        wait_chg(1'b0, 50);
        rx(ADDR_IRQ_STAT, 33'hD);
        @(posedge clk);
        env.analog_fault <= 1'b1;
        repeat (PP + 8) @(posedge clk);
        env.analog_fault <= 1'b0;
        wr(ADDR_CTRL, 32'h18);
        wait_chg(1'b1, 20);
        chk_pin(oe, 1'b0, "status off");
        @(posedge clk);
        env.junction_hot <= 1'b1;
        repeat (150) @(posedge clk);
        env.charge_disable <= 1'b1;
        repeat (6) @(posedge clk);
        env.charge_disable <= 1'b0;
        settle(120);
        chk_pin(chg, 1'b1, "timer restart");
        chk_pin(red, 1'b1, "current reduce");
        wr(ADDR_CTRL, 32'h0B);
        env.boost_or_limit_select <= 1'b1;
        settle(6);
        chk_pin(bst, 1'b1, "boost");
        @(posedge clk);
        env.boost_or_limit_select <= 1'b0;
        env.supply_ok <= 1'b0;
        settle(6);
        chk_pin(bst, 1'b0, "boost");
        chk_pin(slp, 1'b1, "sleep");
        stop_test();
    end
endmodule : test_charger_control_logic
